// >>> igps_core_model.sv
`timescale 1ns/1ps
module igps_core_model
  import igps_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire igps_offer_s irqOffer,
  input wire logic        take,
  input wire logic        doReti,
  output logic            dispatchAck,
  output logic            retiExec
);
  // ==========================================================================
  // Core side: takes an offer a cycle after it shows, never while take is low.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dispatchAck <= 1'h0;
      retiExec <= 1'h0;
    end else begin
      dispatchAck <= take && irqOffer.valid && !dispatchAck;
      retiExec <= doReti && !retiExec;
    end
  end
endmodule

// >>> igps_irq_ctrl.sv
`timescale 1ns/1ps

// Contract
// (RULE1) Every reset loads the interrupt-and-control register with 0C hex.
// (RULE2) Reads are unrestricted; writes change only bits 0, 4, 5, 6 and 7.
// (RULE3) Global enable set lets each source be serviced per its own enable.
// (RULE4) Global enable clear blocks all but power-fail warning, gated by its enable.
// (RULE5) Service level bits 2 and 3 are read-only and read 11 when idle.
// (RULE6) Dispatching a request loads the service level with that request's level.
// (RULE7) Level code: 00 level 0, 01 level 1, 10 level 2, 11 idle.
// (RULE8) Return-from-interrupt instruction sets the service level back to 11.
// (RULE9) Write data for the service level bits is ignored.
module igps_irq_ctrl
  import igps_pkg::*;
#(
  parameter int unsigned NUM_SRC = 8,
  parameter int unsigned PF_IDX  = 7
) (
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                ce,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [IDX_W+1:0]    wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [DATA_W-1:0]   wb_dat_i,
  output logic      [DATA_W-1:0]   wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [NUM_SRC-1:0]  srcReq,
  input  wire logic                dispatchAck,
  input  wire logic                retiExec,
  output igps_offer_s              irqOffer,
  output logic      [1:0]          serviceLevel,
  output logic                     globalIrqEnable
);

  // ==========================================================================
  // Parameter checks.
  // ==========================================================================
  if (NUM_SRC < 1 || NUM_SRC > MAX_SRC) begin : g_bad_num
    $error("NUM_SRC must lie between 1 and 8");
  end
  if (PF_IDX >= NUM_SRC) begin : g_bad_pf
    $error("PF_IDX must name an existing source");
  end

  // ==========================================================================
  // State.
  // ==========================================================================
  logic [7:0]           ic_reg;
  logic [7:0]           ic_next;
  logic [NUM_SRC-1:0]   enable_reg;
  logic [NUM_SRC-1:0]   enable_next;
  logic [2*NUM_SRC-1:0] level_reg;
  logic [2*NUM_SRC-1:0] level_next;
  igps_offer_s          offer_reg;
  igps_offer_s          offer_next;
  logic                 ack_reg;
  logic                 ack_next;
  logic [DATA_W-1:0]    rdata_reg;
  logic [DATA_W-1:0]    rdata_next;
  logic [NUM_SRC-1:0]   allowed;
  logic [IDX_W-1:0]     regIdx;
  logic                 wrStrobe;

  assign regIdx   = wb_adr_i[IDX_W+1:2];
  // A write lands at the edge where the master sees ack high.
  // Gating on ack_reg means a request held over several cycles writes once per ack, and ack rises every second cycle,
  // and a master that drops its request before the ack leaves the registers untouched.
  assign wrStrobe = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & ce;

  // ==========================================================================
  // Per-source gating.
  // ==========================================================================
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_gate
    igps_irq_gate u_gate (
      .req             (srcReq[i]),
      .srcEnable       (enable_reg[i]),
      .globalIrqEnable (ic_reg[IC_GE_BIT]),
      .isPowerfail     (i == PF_IDX),
      .allowed         (allowed[i])
    );
  end

  // ==========================================================================
  // Register file and service level.
  // ==========================================================================
  always_comb begin
    ic_next     = ic_reg;
    enable_next = enable_reg;
    level_next  = level_reg;
    if (wrStrobe && regIdx == IDX_IC && wb_sel_i[0]) begin
      ic_next = (ic_reg & ~IC_WR_MASK) | (wb_dat_i[7:0] & IC_WR_MASK); // see (RULE2) see (RULE9)
    end
    if (wrStrobe && regIdx == IDX_ENABLE && wb_sel_i[0]) begin
      enable_next = wb_dat_i[NUM_SRC-1:0];
    end
    if (wrStrobe && regIdx == IDX_LEVEL) begin
      for (int b = 0; b < 2 * NUM_SRC; b++) begin
        if (wb_sel_i[b / 8]) begin
          level_next[b] = wb_dat_i[b];
        end
      end
    end
    // A dispatch in the same cycle as a return wins, since it starts a new routine.
    if (dispatchAck && offer_reg.valid) begin
      ic_next[IC_LVL_LSB +: 2] = offer_reg.level; // see (RULE6) see (RULE7)
    end else if (retiExec) begin
      ic_next[IC_LVL_LSB +: 2] = LVL_IDLE; // see (RULE8) see (RULE5)
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ic_reg     <= IC_RESET; // see (RULE1)
      enable_reg <= ENABLE_RESET[NUM_SRC-1:0];
      level_reg  <= LEVEL_RESET[2*NUM_SRC-1:0];
    end else if (ce) begin
      ic_reg     <= ic_next;
      enable_reg <= enable_next;
      level_reg  <= level_next;
    end
  end

  // ==========================================================================
  // Request selection: lowest level code wins, ties go to the lowest index.
  // Only a level above the routine now running may interrupt it.
  // ==========================================================================
  always_comb begin
    offer_next = '0;
    offer_next.level = LVL_IDLE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (allowed[i] && level_reg[2*i +: 2] < ic_reg[IC_LVL_LSB +: 2]
          && level_reg[2*i +: 2] <= offer_next.level) begin
        offer_next.valid = 1'b1;
        offer_next.src   = SRC_W'(i);
        offer_next.level = level_reg[2*i +: 2];
      end
    end
    // The offer just taken is withdrawn for one cycle while the level settles.
    if (dispatchAck && offer_reg.valid) begin
      offer_next.valid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      offer_reg <= '0;
    end else if (ce) begin
      offer_reg <= offer_next;
    end
  end

  // ==========================================================================
  // Wishbone slave: ack one cycle after the request, read data with it.
  // ==========================================================================
  always_comb begin
    ack_next   = wb_cyc_i & wb_stb_i & ~ack_reg;
    rdata_next = rdata_reg;
    if (ack_next) begin
      rdata_next = '0;
      unique case (regIdx)
        IDX_IC:     rdata_next[7:0]           = ic_reg;
        IDX_ENABLE: rdata_next[NUM_SRC-1:0]   = enable_reg;
        IDX_LEVEL:  rdata_next[2*NUM_SRC-1:0] = level_reg;
        IDX_PEND:   rdata_next[NUM_SRC-1:0]   = allowed;
        default:    rdata_next                = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else if (ce) begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = rdata_reg;
  assign irqOffer        = offer_reg;
  assign serviceLevel    = ic_reg[IC_LVL_LSB +: 2];
  assign globalIrqEnable = ic_reg[IC_GE_BIT];

endmodule

// >>> igps_irq_ctrl_bench.sv
`timescale 1ns/1ps
module igps_irq_ctrl_bench
  import igps_pkg::*;
;
  logic core_clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, take = 1, doReti = 0;
  logic [7:0] adr = 0, srcReq = 0, r = 8'h37;
  logic [31:0] dat = 0, rdat, expQ[$];
  logic ack, dispatchAck, retiExec, ge;
  logic [1:0] lvl;
  igps_offer_s irqOffer;
  int failCount = 0, cmpCount = 0;
  always #5 core_clk = ~core_clk;
  igps_irq_ctrl dut (.core_clk(core_clk), .rst_b(rst_b), .ce(1'h1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .srcReq(srcReq), .dispatchAck(dispatchAck), .retiExec(retiExec), .irqOffer(irqOffer),
    .serviceLevel(lvl), .globalIrqEnable(ge));
  igps_core_model core (.core_clk(core_clk), .rst_b(rst_b), .irqOffer(irqOffer), .take(take),
    .doReti(doReti), .dispatchAck(dispatchAck), .retiExec(retiExec));
  // ==========================================================================
  // Bus master; for a read, d is the expected data.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) expQ.push_back(d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(negedge core_clk); while (ack !== 1'h1);
    @(posedge core_clk);
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic expectEq(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED %0t output %h expected %h", $time, got, exp);
    end
  endtask
  always @(negedge core_clk) if (ack === 1'h1 && we === 1'h0) begin
    cmpCount++;
    if (rdat !== expQ[0]) begin
      failCount++;
      $display("CHECK FAILED %0t read %h expected %h", $time, rdat, expQ[0]);
    end
    void'(expQ.pop_front());
  end
  task giveVerdict;
    $display("mismatches %0d compares %0d", failCount, cmpCount);
    if (failCount == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    failCount++;
    giveVerdict;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'h1;
    @(posedge core_clk);
    bus(0, 8'h14, 32'h0C);
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      bus(1, 8'h14, {24'h0, r});
      bus(0, 8'h14, {24'h0, r & 8'hF1 | 8'h0C});
    end
    bus(0, 8'h3C, 32'h0);
    bus(1, 8'h18, 32'h84);
    bus(1, 8'h1C, 32'h8010);
    bus(1, 8'h14, 32'h0);
    take <= 1'h0;
    srcReq <= 8'h84;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    expectEq({irqOffer.valid, 2'h0, irqOffer.level, irqOffer.src}, {1'h1, 2'h0, 2'h2, 3'h7});
    @(posedge core_clk);
    take <= 1'h1;
    repeat (4) @(posedge core_clk);
    bus(0, 8'h14, 32'h08);
    bus(1, 8'h14, 32'h01);
    repeat (4) @(posedge core_clk);
    bus(0, 8'h14, 32'h05);
    srcReq <= 8'h0;
    doReti <= 1'h1;
    @(posedge core_clk);
    doReti <= 1'h0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    expectEq({5'h0, ge, lvl}, 8'h07);
    @(posedge core_clk);
    bus(0, 8'h14, 32'h0D);
    rst_b <= 1'h0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'h1;
    @(posedge core_clk);
    bus(0, 8'h14, 32'h0C);
    giveVerdict;
  end
endmodule

// >>> igps_irq_ctrl_props.sv
`timescale 1ns/1ps
module igps_irq_ctrl_props
  import igps_pkg::*;
#(parameter int unsigned PF_IDX = 7) (
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire logic              ce,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [IDX_W+1:0]  wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic              wb_ack_o,
  input wire logic              dispatchAck,
  input wire logic              retiExec,
  input wire igps_offer_s       irqOffer,
  input wire logic [1:0]        serviceLevel,
  input wire logic              globalIrqEnable
);
  // ==========================================================================
  // Checks on the control register, the bus ack and the offer.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic disp;
  logic wrIc;
  assign disp = ce && dispatchAck && irqOffer.valid;
  assign wrIc = ce && wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i[7:2] == IDX_IC && wb_sel_i[0];
  property p_rst; $rose(rst_b) |-> serviceLevel == LVL_IDLE && !globalIrqEnable; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_ack; ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_ge; wrIc |=> globalIrqEnable == $past(wb_dat_i[0]); endproperty
  a_ge: assert property (p_ge) else $error("enable write");
  property p_hold; ce && !dispatchAck && !retiExec |=> $stable(serviceLevel); endproperty
  a_hold: assert property (p_hold) else $error("level moved");
  property p_disp; disp |=> serviceLevel == $past(irqOffer.level); endproperty
  a_disp: assert property (p_disp) else $error("dispatch level");
  property p_return_from_interrupt_instr; ce && retiExec && !disp |=> serviceLevel == LVL_IDLE; endproperty
  a_return_from_interrupt_instr: assert property (p_return_from_interrupt_instr) else $error("return level");
  property p_pf; irqOffer.valid && !$past(globalIrqEnable) |-> irqOffer.src == PF_IDX; endproperty
  a_pf: assert property (p_pf) else $error("blocked source");
  property p_lvl; irqOffer.valid |-> irqOffer.level != LVL_IDLE && irqOffer.level < serviceLevel; endproperty
  a_lvl: assert property (p_lvl) else $error("offer level");
  c_disp: cover property (disp);
  c_return_from_interrupt_instr: cover property (ce && retiExec);
  c_wr: cover property (wrIc);
endmodule

bind igps_irq_ctrl igps_irq_ctrl_props #(.PF_IDX(PF_IDX)) u_props (.*);

// >>> igps_irq_gate.sv
`timescale 1ns/1ps

module igps_irq_gate (
  input  wire logic req,
  input  wire logic srcEnable,
  input  wire logic globalIrqEnable,
  input  wire logic isPowerfail,
  output logic      allowed
);

  // The power-fail warning ignores the global enable and obeys only its own enable.
  assign allowed = req & srcEnable & (globalIrqEnable | isPowerfail); // see (RULE3) see (RULE4)

endmodule

// >>> igps_pkg.sv
package igps_pkg;

  // ==========================================================================
  // Bus geometry and register indices (byte address is four times the index).
  // ==========================================================================
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned IDX_W      = 6;
  localparam int unsigned MAX_SRC    = 8;
  localparam int unsigned SRC_W      = 3;
  localparam logic [5:0]  IDX_IC     = 6'h05;
  localparam logic [5:0]  IDX_ENABLE = 6'h06;
  localparam logic [5:0]  IDX_LEVEL  = 6'h07;
  localparam logic [5:0]  IDX_PEND   = 6'h08;

  // ==========================================================================
  // Interrupt-and-control register layout.
  // ==========================================================================
  localparam logic [7:0]  IC_RESET   = 8'h0C;
  localparam logic [7:0]  IC_WR_MASK = 8'hF1;
  localparam int unsigned IC_GE_BIT  = 0;
  localparam int unsigned IC_LVL_LSB = 2;
  localparam logic [1:0]  LVL_IDLE   = 2'h3;
  localparam logic [15:0] LEVEL_RESET  = 16'h0000;
  localparam logic [7:0]  ENABLE_RESET = 8'h00;

  typedef struct packed {
    logic             valid;
    logic [SRC_W-1:0] src;
    logic [1:0]       level;
  } igps_offer_s;

endpackage
